// ---- bench/tts_port_model.sv ----
/* Digital port and neighbour-channel model driving the trigger inputs.
   Assumes the bench calls its tasks; all changes follow a rising edge. */
`timescale 1ns/1ns
`default_nettype none
module tts_port_model #(
    parameter int PINS  = 7,
    parameter int CHANS = 4
) (
    input  wire logic             clk,
    output logic      [PINS-1:0]  pin_in,
    output logic      [PINS-1:0]  pin_is_trig_in,
    output logic      [CHANS-1:0] chan_trigger_output_pin_function_in
);
    initial begin
        pin_in = '0;
        pin_is_trig_in = '0;
        chan_trigger_output_pin_function_in = '0;
    end

    task automatic cfg_pins(input logic [PINS-1:0] m);
        @(posedge clk);
        pin_is_trig_in <= m;
    endtask : cfg_pins

    // Held 3 cycles each way: the synchroniser needs two
    task automatic pulse(input bit chan, input int n);
        @(posedge clk);
        if (chan) chan_trigger_output_pin_function_in[n] <= 1'b1;
        else pin_in[n] <= 1'b1;
        repeat (3) @(posedge clk);
        chan_trigger_output_pin_function_in <= '0;
        pin_in <= '0;
        repeat (3) @(posedge clk);
    endtask : pulse
endmodule : tts_port_model
`default_nettype wire

// ---- bench/tts_sequencer_sva.sv ----
/* Port checker for the trigger sequencer.
   Assumes it is bound to every tts_sequencer instance. */
`timescale 1ns/1ns
`default_nettype none
module tts_sequencer_sva
    import tts_pkg::*;
#(
    parameter int PINS       = 7,
    parameter int CHANS      = 4,
    parameter int SETTLE_CYC = 8
) (
    input wire logic              clk,
    input wire logic              srst,
    input wire tts_pkg::tts_bus_s bus,
    input wire logic [31:0]       rdata,
    input wire logic [PINS-1:0]   pin_in,
    input wire logic [PINS-1:0]   pin_is_trig_in,
    input wire logic [CHANS-1:0]  chan_trigger_output_pin_function_in,
    input wire logic              trig_out,
    input wire logic [31:0]       active_level,
    input wire logic              step_strobe,
    input wire logic              irq
);
    import tts_pkg::*;
    logic cmd_abort;
    assign cmd_abort = bus.wr && bus.addr == TTS_ADDR_CMD && bus.wdata[TTS_CMD_ABORT];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    chk_reset_quiet: assert property ($fell(srst) |-> !trig_out && !step_strobe && !irq && rdata == 32'h0)
        else $error("outputs not quiet after reset");
    chk_rdata_idle: assert property (!bus.rd |=> rdata == 32'h0)
        else $error("read data outside read slot");
    chk_strobe_single: assert property (step_strobe |=> !step_strobe)
        else $error("step strobe longer than one cycle");
    chk_trigger_output_pin_function_len: assert property ($rose(trig_out) |-> trig_out [*3] ##1 !trig_out)
        else $error("trigger out not three cycles");
    chk_trigger_output_pin_function_step: assert property ($rose(trig_out) |-> step_strobe)
        else $error("trigger out without a step");
    chk_abort_quiet: assert property (cmd_abort |=> !step_strobe [*4])
        else $error("step after abort");
    chk_level_cause: assert property (!$stable(active_level) |-> step_strobe)
        else $error("active level moved without a step");
    chk_mask_irq: assert property (bus.wr && bus.addr == TTS_ADDR_IRQ_MK && bus.wdata[2:0] == 3'h0 |=> !irq)
        else $error("interrupt with mask cleared");

    cover property (step_strobe && trig_out);
    cover property ($rose(irq));
    cover property (cmd_abort);
endmodule : tts_sequencer_sva
bind tts_sequencer tts_sequencer_sva #(.PINS(PINS), .CHANS(CHANS), .SETTLE_CYC(SETTLE_CYC)) i_sva (
    .clk, .srst, .bus, .rdata, .pin_in, .pin_is_trig_in, .chan_trigger_output_pin_function_in,
    .trig_out, .active_level, .step_strobe, .irq);
`default_nettype wire

// ---- bench/tts_sequencer_tb.sv ----
/* Self-checking bench for the trigger sequencer.
   Assumes a short settle count; port model drives pins and channels. */
`timescale 1ns/1ns
`default_nettype none
module tts_sequencer_tb;
    import tts_pkg::*;
    localparam int SETTLE = 8;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    tts_bus_s    bus = '0;
    logic [31:0] rdata;
    logic [6:0]  pin_in;
    logic [6:0]  pin_is_trig_in;
    logic [3:0]  chan_trigger_output_pin_function_in;
    logic        trig_out;
    logic [31:0] active_level;
    logic        step_strobe;
    logic        irq;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          n_steps = 0;
    int          n_trigger_output_pin_function = 0;

    always #4 clk = ~clk;
    always @(negedge clk) if (step_strobe === 1'b1) n_steps++;
    always @(negedge clk) if (trig_out === 1'b1) n_trigger_output_pin_function++;

    tts_sequencer #(.SETTLE_CYC(SETTLE)) i_dut (.clk, .srst, .bus, .rdata, .pin_in, .pin_is_trig_in,
        .chan_trigger_output_pin_function_in, .trig_out, .active_level, .step_strobe, .irq);
    tts_port_model i_port (.clk, .pin_in, .pin_is_trig_in, .chan_trigger_output_pin_function_in);

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        check(what, rdata, exp);
    endtask : rd

    task automatic t_reset();
        rd("oper", TTS_ADDR_OPER, 32'h0);
        rd("unmapped", 8'h20, 32'h0);
        rd("ctrl", TTS_ADDR_CTRL, TTS_RST_CTRL);
        rd("cmd", TTS_ADDR_CMD, 32'h0);
        i_port.cfg_pins(7'h24);
        wr(TTS_ADDR_SRC, 32'h2);
        rd("src", TTS_ADDR_SRC, 32'h2);
        i_port.pulse(1'b0, 5);
        wr(TTS_ADDR_CMD, 32'h4);
        repeat (8) @(posedge clk);
        check("idle steps", 32'(n_steps), 32'h0);
    endtask : t_reset

    // One pass each for bus, ext and pin sources, two for channel; the last fires by software on a silent channel, trigger-out off
    task automatic t_sources();
        logic [31:0] src [5] = '{32'h0, 32'h2, 32'h203, 32'h104, 32'h304};
        int kind [5] = '{0, 1, 1, 2, 3};
        int idx [5] = '{0, 5, 2, 1, 0};
        int n0;
        int t0;
        for (int i = 0; i < 5; i++) begin
            wr(TTS_ADDR_CTRL, (i == 4) ? 32'h4 : 32'h6);
            wr(TTS_ADDR_LEVEL, 32'hA0 + i);
            wr(TTS_ADDR_SRC, src[i]);
            n0 = n_steps;
            t0 = n_trigger_output_pin_function;
            wr(TTS_ADDR_CMD, 32'h1);
            rd("settling", TTS_ADDR_OPER, 32'h40);
            wr(TTS_ADDR_CMD, 32'h4);
            repeat (SETTLE + 40) @(posedge clk);
            i_port.pulse(1'b0, 0);
            rd("waiting", TTS_ADDR_OPER, 32'h50);
            check("early steps", 32'(n_steps - n0), 32'h0);
            case (kind[i])
                0: wr(TTS_ADDR_CMD, 32'h8);
                1: i_port.pulse(1'b0, idx[i]);
                2: i_port.pulse(1'b1, idx[i]);
                default: wr(TTS_ADDR_CMD, 32'h4);
            endcase
            for (int w = 0; w < 30 && n_steps == n0; w++) @(posedge clk);
            repeat (6) @(posedge clk);
            check("steps", 32'(n_steps - n0), 32'h1);
            check("level", active_level, 32'hA0 + i);
            check("trig out", 32'(n_trigger_output_pin_function - t0), (i == 4) ? 32'h0 : 32'h3);
            rd("active", TTS_ADDR_ACTIVE, 32'hA0 + i);
            rd("idle", TTS_ADDR_OPER, 32'h0);
        end
    endtask : t_sources

    task automatic t_abort_fixed();
        int n0 = n_steps;
        int t0 = n_trigger_output_pin_function;
        wr(TTS_ADDR_SRC, 32'h0);
        wr(TTS_ADDR_CMD, 32'h1);
        repeat (SETTLE + 4) @(posedge clk);
        wr(TTS_ADDR_CMD, 32'hA);
        rd("aborted", TTS_ADDR_OPER, 32'h0);
        wr(TTS_ADDR_CTRL, 32'h0);
        wr(TTS_ADDR_LEVEL, 32'h77);
        rd("level reg", TTS_ADDR_LEVEL, 32'h77);
        wr(TTS_ADDR_CMD, 32'h1);
        repeat (SETTLE + 4) @(posedge clk);
        wr(TTS_ADDR_CMD, 32'h8);
        repeat (8) @(posedge clk);
        check("no steps", 32'(n_steps - n0), 32'h0);
        check("no trig out", 32'(n_trigger_output_pin_function - t0), 32'h0);
        check("kept level", active_level, 32'hA4);
        rd("fixed idle", TTS_ADDR_OPER, 32'h0);
    endtask : t_abort_fixed

    task automatic t_cont_irq();
        int n0 = n_steps;
        wr(TTS_ADDR_CTRL, 32'h7);
        wr(TTS_ADDR_SRC, 32'h1);
        wr(TTS_ADDR_CMD, 32'h1);
        repeat (60) @(posedge clk);
        check("rearm", 32'(n_steps - n0 >= 3), 32'h1);
        wr(TTS_ADDR_CMD, 32'h2);
        rd("cont abort", TTS_ADDR_OPER, 32'h0);
        check("irq masked", 32'(irq), 32'h0);
        wr(TTS_ADDR_IRQ_MK, 32'h7);
        rd("irq status", TTS_ADDR_IRQ_ST, 32'h7);
        check("irq", 32'(irq), 32'h1);
        wr(TTS_ADDR_IRQ_MK, 32'h0);
        rd("mask off", TTS_ADDR_IRQ_MK, 32'h0);
        check("irq mask off", 32'(irq), 32'h0);
        wr(TTS_ADDR_IRQ_MK, 32'h7);
        wr(TTS_ADDR_IRQ_ST, 32'h7);
        rd("irq clear", TTS_ADDR_IRQ_ST, 32'h0);
        check("irq off", 32'(irq), 32'h0);
    endtask : t_cont_irq

    task automatic wrap_up();
        if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_sources();
        t_abort_fixed();
        t_cont_irq();
        wrap_up();
    end
endmodule : tts_sequencer_tb
`default_nettype wire

// ---- verilog/tts_edge_sync.sv ----
/*
 * Two-flop synchroniser with rising-edge detector, one lane per bit.
 * Assumes inputs are asynchronous to clk and held at least two cycles.
 */
`timescale 1ns/1ns
`default_nettype none
module tts_edge_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (srst) begin
            meta <= '0;
            sync <= '0;
            prev <= '0;
            rise <= '0;
        end else begin
            meta <= async_in;
            sync <= meta;
            prev <= sync;
            rise <= sync & ~prev;
        end
    end
endmodule : tts_edge_sync
`default_nettype wire

// ---- verilog/tts_pkg.sv ----
/*
 * Package for the transient trigger sequencer: register map, field
 * positions, reset values, trigger source codes and timing constants.
 * Assumes a single 125 MHz system clock.
 */
package tts_pkg;

    // Register byte addresses
    localparam logic [7:0] TTS_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] TTS_ADDR_SRC    = 8'h04;
    localparam logic [7:0] TTS_ADDR_CMD    = 8'h08;
    localparam logic [7:0] TTS_ADDR_OPER   = 8'h0C;
    localparam logic [7:0] TTS_ADDR_IRQ_ST = 8'h10;
    localparam logic [7:0] TTS_ADDR_IRQ_MK = 8'h14;
    localparam logic [7:0] TTS_ADDR_LEVEL  = 8'h18;
    localparam logic [7:0] TTS_ADDR_ACTIVE = 8'h1C;

    // Control register fields
    localparam int TTS_CTRL_CONT  = 0;
    localparam int TTS_CTRL_TRIGGER_OUTPUT_PIN_FUNCTION  = 1;
    localparam int TTS_CTRL_STEP  = 2;

    // Command register fields (write-only pulses)
    localparam int TTS_CMD_ARM    = 0;
    localparam int TTS_CMD_ABORT  = 1;
    localparam int TTS_CMD_TRIG   = 2;
    localparam int TTS_CMD_BUS    = 3;

    // Operation condition word fields
    localparam int TTS_OPER_WTG   = 4;
    localparam int TTS_OPER_ACT   = 6;

    // Interrupt status fields
    localparam int TTS_IRQ_READY  = 0;
    localparam int TTS_IRQ_STEP   = 1;
    localparam int TTS_IRQ_DONE   = 2;
    localparam int TTS_IRQ_W      = 3;

    localparam logic [31:0] TTS_RST_CTRL  = 32'h0000_0000;
    localparam logic [31:0] TTS_RST_SRC   = 32'h0000_0000;
    localparam logic [31:0] TTS_RST_LEVEL = 32'h0000_0000;
    localparam logic [TTS_IRQ_W-1:0] TTS_RST_MASK = 3'h0;

    // Trigger source selection codes
    localparam logic [2:0] TTS_SRC_BUS  = 3'h0;
    localparam logic [2:0] TTS_SRC_IMM  = 3'h1;
    localparam logic [2:0] TTS_SRC_EXT  = 3'h2;
    localparam logic [2:0] TTS_SRC_PIN  = 3'h3;
    localparam logic [2:0] TTS_SRC_CHAN = 3'h4;

    // Timing
    localparam int TTS_CLK_MHZ      = 125;
    localparam int TTS_SETTLE_US    = 2000;
    localparam int TTS_SETTLE_CYC   = TTS_SETTLE_US * TTS_CLK_MHZ;
    localparam int TTS_ACTION_CYC   = 4;
    localparam int TTS_TRIGGER_OUTPUT_PIN_FUNCTION_CYC     = 2;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } tts_bus_s;

    typedef enum logic [3:0] {
        TTS_IDLE   = 4'b0001,
        TTS_SETTLE = 4'b0010,
        TTS_WAIT   = 4'b0100,
        TTS_ACTION = 4'b1000
    } tts_state_e;

endpackage : tts_pkg

// ---- verilog/tts_sequencer.sv ----
/*
 * Transient trigger sequencer for one output channel: arm, settle, wait,
 * step and optional re-arm, with register port and interrupt.
 * Assumes pins arrive asynchronous; register master on the same clock.
 */
// Overview of operation
// - Selectable source: bus, immediate, ext, pin, channel
// - Idle after reset, all triggers discarded
// - Arm command moves idle to initiated
// - Triggers before settling complete are discarded
// - Waiting flag at bit 4 when ready
// - Return idle unless continuous arming re-arms
// - Software trigger fires regardless of source
// - Pin or channel source waits without timeout
// - Abort returns idle from any state
// - Trigger loads level, then returns idle
// - Transient-active flag at bit 6
// - Trigger-out pulse on each step if enabled
// - Step mode loads level, fixed mode ignores
// - Function not step-enabled takes no action
`timescale 1ns/1ns
`default_nettype none
module tts_sequencer
    import tts_pkg::*;
#(
    parameter int PINS       = 7,
    parameter int CHANS      = 4,
    parameter int SETTLE_CYC = tts_pkg::TTS_SETTLE_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire tts_pkg::tts_bus_s     bus,
    output logic [31:0]                rdata,
    input  wire logic [PINS-1:0]       pin_in,
    input  wire logic [PINS-1:0]       pin_is_trig_in,
    input  wire logic [CHANS-1:0]      chan_trigger_output_pin_function_in,
    output logic                       trig_out,
    output logic [31:0]                active_level,
    output logic                       step_strobe,
    output logic                       irq
);
    import tts_pkg::*;

    tts_state_e       state;
    logic [31:0]      ctrl;
    logic [31:0]      src;
    logic [31:0]      level;
    logic [TTS_IRQ_W-1:0] irq_st;
    logic [TTS_IRQ_W-1:0] irq_mk;
    logic [31:0]      settle_cnt;
    logic [2:0]       act_cnt;
    logic [2:0]       trigger_output_pin_function_cnt;
    logic [PINS-1:0]  pin_rise;
    logic [CHANS-1:0] chan_rise;
    logic             cmd_wr;
    logic             arm_cmd;
    logic             abort_cmd;
    logic             soft_trig;
    logic             bus_trig;
    logic             src_trig;
    logic             fire;
    logic             ready_ev;
    logic             step_ev;
    logic             done_ev;
    logic [2:0]       src_sel;
    logic [7:0]       src_idx;

    // Pin and channel inputs cross into clk here
    tts_edge_sync #(.WIDTH(PINS)) u_pin_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (pin_in),
        .rise     (pin_rise)
    );

    tts_edge_sync #(.WIDTH(CHANS)) u_chan_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (chan_trigger_output_pin_function_in),
        .rise     (chan_rise)
    );

    assign cmd_wr    = bus.wr && (bus.addr == TTS_ADDR_CMD);
    assign arm_cmd   = cmd_wr && bus.wdata[TTS_CMD_ARM];
    assign abort_cmd = cmd_wr && bus.wdata[TTS_CMD_ABORT];
    assign soft_trig = cmd_wr && bus.wdata[TTS_CMD_TRIG];
    assign bus_trig  = cmd_wr && bus.wdata[TTS_CMD_BUS];
    assign src_sel   = src[2:0];
    assign src_idx   = src[15:8];

    // Source mux; pins only count when configured as inputs
    always_comb begin
        src_trig = 1'b0;
        unique case (src_sel)
            TTS_SRC_BUS:  src_trig = bus_trig;
            TTS_SRC_IMM:  src_trig = 1'b1;
            TTS_SRC_EXT:  src_trig = |(pin_rise & pin_is_trig_in);
            TTS_SRC_PIN: begin
                if (int'(src_idx) < PINS) begin
                    src_trig = pin_rise[src_idx[$clog2(PINS)-1:0]] &
                               pin_is_trig_in[src_idx[$clog2(PINS)-1:0]];
                end
            end
            TTS_SRC_CHAN: begin
                if (int'(src_idx) < CHANS) begin
                    src_trig = chan_rise[src_idx[$clog2(CHANS)-1:0]];
                end
            end
            default: src_trig = 1'b0;
        endcase
    end

    // Only honoured in WAIT; earlier triggers fall away
    assign fire     = (state == TTS_WAIT) && !abort_cmd && (src_trig || soft_trig);
    assign ready_ev = (state == TTS_SETTLE) && !abort_cmd &&
                      (settle_cnt >= 32'(SETTLE_CYC - 1));
    assign step_ev  = fire;
    assign done_ev  = (state == TTS_ACTION) && !abort_cmd &&
                      (act_cnt == 3'(TTS_ACTION_CYC - 1));

    // Sequencer state
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= TTS_IDLE;
        end else if (abort_cmd) begin
            state <= TTS_IDLE;
        end else begin
            unique case (state)
                TTS_IDLE: begin
                    if (arm_cmd) begin
                        state <= TTS_SETTLE;
                    end
                end
                TTS_SETTLE: begin
                    if (ready_ev) begin
                        state <= TTS_WAIT;
                    end
                end
                TTS_WAIT: begin
                    if (fire) begin
                        state <= TTS_ACTION;
                    end
                end
                TTS_ACTION: begin
                    if (done_ev) begin
                        state <= ctrl[TTS_CTRL_CONT] ? TTS_SETTLE : TTS_IDLE;
                    end
                end
                default: state <= TTS_IDLE;
            endcase
        end
    end

    // Settling counter, cleared outside SETTLE
    always_ff @(posedge clk) begin
        if (srst || state != TTS_SETTLE) begin
            settle_cnt <= '0;
        end else begin
            settle_cnt <= settle_cnt + 32'h0000_0001;
        end
    end

    // Action duration counter
    always_ff @(posedge clk) begin
        if (srst || state != TTS_ACTION) begin
            act_cnt <= '0;
        end else begin
            act_cnt <= act_cnt + 3'h1;
        end
    end

    // Level load on accepted trigger, step mode only
    always_ff @(posedge clk) begin
        if (srst) begin
            active_level <= TTS_RST_LEVEL;
            step_strobe  <= 1'b0;
        end else begin
            step_strobe <= fire && ctrl[TTS_CTRL_STEP];
            if (fire && ctrl[TTS_CTRL_STEP]) begin
                active_level <= level;
            end
        end
    end

    // Trigger-out pulse; three cycles so the far synchroniser sees it
    always_ff @(posedge clk) begin
        if (srst) begin
            trigger_output_pin_function_cnt <= '0;
            trig_out <= 1'b0;
        end else begin
            if (fire && ctrl[TTS_CTRL_TRIGGER_OUTPUT_PIN_FUNCTION] && ctrl[TTS_CTRL_STEP]) begin
                trigger_output_pin_function_cnt <= 3'(TTS_TRIGGER_OUTPUT_PIN_FUNCTION_CYC);
            end else if (trigger_output_pin_function_cnt != 3'h0) begin
                trigger_output_pin_function_cnt <= trigger_output_pin_function_cnt - 3'h1;
            end
            trig_out <= (trigger_output_pin_function_cnt != 3'h0) ||
                        (fire && ctrl[TTS_CTRL_TRIGGER_OUTPUT_PIN_FUNCTION] && ctrl[TTS_CTRL_STEP]);
        end
    end

    // Configuration registers
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl  <= TTS_RST_CTRL;
            src   <= TTS_RST_SRC;
            level <= TTS_RST_LEVEL;
        end else if (bus.wr) begin
            if (bus.addr == TTS_ADDR_CTRL) begin
                ctrl <= bus.wdata & 32'h0000_0007;
            end
            if (bus.addr == TTS_ADDR_SRC) begin
                src <= bus.wdata & 32'h0000_FF07;
            end
            if (bus.addr == TTS_ADDR_LEVEL) begin
                level <= bus.wdata;
            end
        end
    end

    // Sticky events; a new event beats a write-one clear
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_st <= '0;
            irq_mk <= TTS_RST_MASK;
        end else begin
            if (bus.wr && bus.addr == TTS_ADDR_IRQ_MK) begin
                irq_mk <= bus.wdata[TTS_IRQ_W-1:0];
            end
            irq_st <= (irq_st & ~((bus.wr && bus.addr == TTS_ADDR_IRQ_ST) ?
                                  bus.wdata[TTS_IRQ_W-1:0] : '0))
                      | {done_ev, step_ev, ready_ev};
        end
    end

    assign irq = |(irq_st & irq_mk);

    // Read port, data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= '0;
        end else if (bus.rd) begin
            unique case (bus.addr)
                TTS_ADDR_CTRL:   rdata <= ctrl;
                TTS_ADDR_SRC:    rdata <= src;
                TTS_ADDR_OPER: begin
                    rdata <= '0;
                    rdata[TTS_OPER_WTG] <= (state == TTS_WAIT);
                    rdata[TTS_OPER_ACT] <= (state != TTS_IDLE);
                end
                TTS_ADDR_IRQ_ST: rdata <= 32'(irq_st);
                TTS_ADDR_IRQ_MK: rdata <= 32'(irq_mk);
                TTS_ADDR_LEVEL:  rdata <= level;
                TTS_ADDR_ACTIVE: rdata <= active_level;
                default:         rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

endmodule : tts_sequencer
`default_nettype wire
